// ### src/phpc_top.sv
// Peak and hold predriver control with serial configuration port
`timescale 1ns/1ps
`include "phpc_defs.svh"

module phpc_top (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic sclk_i,
  input wire logic chip_select_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  input wire logic output_permit_in_i,
  input wire logic cycle_ctrl_i,
  input wire logic dwell_source_sel_i,
  input wire phpc_pkg::phpc_dac_t load_current_i,
  input wire phpc_pkg::phpc_flt_t fault_detect_i,
  output logic gate_drive_o,
  output logic clamp_drive_o,
  output logic loop_state_o,
  output logic fault_n_o,
  output logic fault_oe_o
);
  import phpc_pkg::*;

  // Serial clock domain

  logic spi_rst_n;
  logic [`PHPC_CNT_W-1:0] bit_cnt;
  logic [`PHPC_CNT_W-1:0] out_idx;
  logic [`PHPC_WORD_W-2:0] rx_sr;
  phpc_frame_t rx_word;
  logic rx_tgl;
  logic word_done;
  phpc_reply_t reply;
  logic [`PHPC_WORD_W-1:0] reply_bits;
  logic [`PHPC_CNT_W-1:0] tx_pos;

  // Chip-select high holds the bit counters in reset, so a short
  // frame is dropped and the next frame starts at bit 0
  assign spi_rst_n = resetn_i & ~chip_select_n_i; // [RQ4]
  assign word_done = (bit_cnt == `PHPC_LAST_BIT); // [RQ7]

  always_ff @(posedge sclk_i or negedge spi_rst_n)
  begin
    if (!spi_rst_n)
    begin
      bit_cnt <= '0;
      rx_sr <= '0;
    end
    else
    begin
      bit_cnt <= bit_cnt + 4'h1;
      rx_sr <= {rx_sr[`PHPC_WORD_W-3:0], sdi_i}; // [RQ5]
    end
  end

  // The received word survives chip-select; only resetn_i clears it
  always_ff @(posedge sclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rx_word <= '0;
      rx_tgl <= 1'b0;
    end
    else if (word_done && !chip_select_n_i)
    begin
      rx_word <= {rx_sr, sdi_i}; // [RQ7]
      rx_tgl <= ~rx_tgl;
    end
  end

  // Output changes on the falling edge, half a bit ahead of sampling
  always_ff @(negedge sclk_i or negedge spi_rst_n)
  begin
    if (!spi_rst_n)
    begin
      out_idx <= '0;
    end
    else
    begin
      out_idx <= bit_cnt;
    end
  end

  // Reply is quasi-static: it changes only a few core cycles after
  // a frame ends, so the host must leave a gap between frames
  assign reply_bits = reply;
  assign tx_pos = `PHPC_LAST_BIT - out_idx;
  assign sdo_o = reply_bits[tx_pos]; // [RQ6]
  assign sdo_oe_o = ~chip_select_n_i; // [RQ6]

  // Core clock domain

  logic rx_tgl_s1;
  logic rx_tgl_s2;
  logic rx_tgl_s3;
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic dwell_d;
  phpc_flt_t flt_s1;
  phpc_flt_t flt_s2;
  logic cmd_evt;

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rx_tgl_s1 <= 1'b0;
      rx_tgl_s2 <= 1'b0;
      rx_tgl_s3 <= 1'b0;
      pin_s1 <= '0;
      pin_s2 <= '0;
      dwell_d <= 1'b0;
      flt_s1 <= '0;
      flt_s2 <= '0;
    end
    else
    begin
      rx_tgl_s1 <= rx_tgl;
      rx_tgl_s2 <= rx_tgl_s1;
      rx_tgl_s3 <= rx_tgl_s2;
      pin_s1 <= {output_permit_in_i, cycle_ctrl_i, dwell_source_sel_i};
      pin_s2 <= pin_s1;
      dwell_d <= pin_s2[0];
      flt_s1 <= fault_detect_i;
      flt_s2 <= flt_s1;
    end
  end

  assign cmd_evt = rx_tgl_s2 ^ rx_tgl_s3;

  // Register file

  logic [7:0] aux_cfg;
  phpc_dac_t peak_dac;
  phpc_dac_t hold_dac;
  phpc_flt_t fault_sticky;
  phpc_flt_t next_fault;
  logic wr_aux;
  logic wr_peak;
  logic wr_hold;
  logic rd_status;

  function automatic logic [7:0] rd_value(
    input logic [2:0] addr,
    input logic [7:0] aux,
    input phpc_dac_t pk,
    input phpc_dac_t hd,
    input phpc_flt_t flt
  );
    case (addr)
      `PHPC_REG_STATUS: rd_value = {4'h0, flt};
      `PHPC_REG_AUX: rd_value = aux;
      `PHPC_REG_PEAK: rd_value = {1'b0, pk};
      `PHPC_REG_HOLD: rd_value = {1'b0, hd};
      default: rd_value = 8'h00;
    endcase
  endfunction

  assign wr_aux = cmd_evt & rx_word.wr & (rx_word.addr == `PHPC_REG_AUX);
  assign wr_peak = cmd_evt & rx_word.wr
    & (rx_word.addr == `PHPC_REG_PEAK);
  assign wr_hold = cmd_evt & rx_word.wr
    & (rx_word.addr == `PHPC_REG_HOLD);
  assign rd_status = cmd_evt & ~rx_word.wr
    & (rx_word.addr == `PHPC_REG_STATUS);

  // Read of the status clears it, but a fault present that cycle stays
  assign next_fault = (rd_status ? '0 : fault_sticky) | flt_s2;

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      aux_cfg <= `PHPC_AUX_RESET; // [RQ12]
      peak_dac <= `PHPC_PEAK_RESET; // [RQ12]
      hold_dac <= `PHPC_HOLD_RESET; // [RQ12]
      fault_sticky <= '0;
      reply <= '0;
    end
    else
    begin
      if (wr_aux)
        aux_cfg <= rx_word.data;
      if (wr_peak)
        peak_dac <= rx_word.data[`PHPC_DAC_W-1:0]; // [RQ8]
      if (wr_hold)
        hold_dac <= rx_word.data[`PHPC_DAC_W-1:0]; // [RQ8]
      fault_sticky <= next_fault;
      if (cmd_evt)
      begin
        reply.faults <= fault_sticky; // [RQ11]
        reply.rsvd <= 1'b0;
        reply.addr <= rx_word.addr;
        reply.data <= rd_value(rx_word.addr, aux_cfg, peak_dac,
          hold_dac, fault_sticky); // [RQ11]
      end
    end
  end

  // Dwell phase control

  logic cmd_on;
  logic level_mode;
  logic dwell_lvl;
  logic dwell_rise;
  logic [`PHPC_DWELL_W-1:0] dwell_len;
  logic [`PHPC_DWELL_W-1:0] dwell_cnt;
  logic [`PHPC_DWELL_W-1:0] next_cnt;
  phpc_phase_t phase;
  phpc_phase_t next_phase;

  assign cmd_on = pin_s2[2] & pin_s2[1]; // [RQ1]
  assign level_mode = aux_cfg[`PHPC_AUX_DWELL_SRC]; // [RQ3]
  assign dwell_lvl = pin_s2[0];
  assign dwell_rise = pin_s2[0] & ~dwell_d;
  assign dwell_len = aux_cfg[`PHPC_AUX_DWELL_LSB +: `PHPC_DWELL_W];

  // In clock mode the peak lasts dwell_len+1 dwell-clock edges
  always_comb
  begin
    next_phase = phase;
    next_cnt = dwell_cnt;
    case (phase)
      PH_IDLE:
      begin
        next_cnt = '0;
        if (cmd_on)
          next_phase = (level_mode && !dwell_lvl) ? PH_HOLD : PH_PEAK;
      end
      PH_PEAK:
      begin
        if (!cmd_on)
          next_phase = PH_IDLE;
        else if (level_mode)
        begin
          if (!dwell_lvl)
            next_phase = PH_HOLD; // [RQ3]
        end
        else if (dwell_rise)
        begin
          if (dwell_cnt == dwell_len)
            next_phase = PH_HOLD; // [RQ2]
          else
            next_cnt = dwell_cnt + 3'h1;
        end
      end
      PH_HOLD:
      begin
        if (!cmd_on)
          next_phase = PH_IDLE;
        else if (level_mode && dwell_lvl)
          next_phase = PH_PEAK; // [RQ3]
      end
      default:
      begin
        next_phase = PH_IDLE;
        next_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      phase <= PH_IDLE;
      dwell_cnt <= '0;
    end
    else
    begin
      phase <= next_phase;
      dwell_cnt <= next_cnt;
    end
  end

  // Current regulation

  phpc_dac_t ref_level;
  logic at_ref;
  logic any_fault;

  assign ref_level = (phase == PH_PEAK) ? peak_dac : hold_dac; // [RQ2]
  assign at_ref = (load_current_i >= ref_level); // [RQ8]
  assign any_fault = |next_fault;

  // Gate stays off under a latched fault until software clears it
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      gate_drive_o <= 1'b0; // [RQ12]
      clamp_drive_o <= 1'b0; // [RQ12]
      loop_state_o <= 1'b0;
      fault_oe_o <= 1'b0;
    end
    else
    begin
      gate_drive_o <= cmd_on & ~at_ref & ~any_fault; // [RQ1] [RQ8]
      clamp_drive_o <= cmd_on & at_ref & ~any_fault; // [RQ1] [RQ8]
      loop_state_o <= at_ref; // [RQ9]
      fault_oe_o <= any_fault; // [RQ10]
    end
  end

  // Open drain: only ever drives low
  assign fault_n_o = 1'b0; // [RQ10]

endmodule // phpc_top

// ### shared/phpc_defs.svh
// Constants for the peak and hold predriver controller
// How it works
// RQ1: Predriver outputs commanded only when permit AND cycle-control high.
// RQ2: Dwell-select input picks which DAC pair supplies the reference.
// RQ3: Option bit 3 picks clock (0, default) or level (1) dwell-select input.
// RQ4: Chip-select low opens a frame; serial exchange happens only then.
// RQ5: Serial input bits shift into the shift register on serial clock edges.
// RQ6: Serial output shifts on serial clock; released while chip-select high.
// RQ7: Every serial frame carries one 16-bit word.
// RQ8: Load current compared to 7-bit peak/hold levels; load regulated there.
// RQ9: Loop-state output is low below the selected reference, high otherwise.
// RQ10: A detected fault pulls the open-drain fault output low at once; here it goes low three core clock cycles later.
// RQ11: Fault diagnostics are readable over the serial port.
// RQ12: Reset restores register defaults and holds both predriver outputs off.
`ifndef PHPC_DEFS_SVH
`define PHPC_DEFS_SVH

`define PHPC_WORD_W 16
`define PHPC_DAC_W 7
`define PHPC_FLT_W 4
`define PHPC_CNT_W 4
`define PHPC_DWELL_W 3

`define PHPC_REG_STATUS 3'h0
`define PHPC_REG_AUX 3'h1
`define PHPC_REG_PEAK 3'h2
`define PHPC_REG_HOLD 3'h3

`define PHPC_AUX_DWELL_SRC 3
`define PHPC_AUX_DWELL_LSB 0

`define PHPC_AUX_RESET 8'h00
`define PHPC_PEAK_RESET 7'h40
`define PHPC_HOLD_RESET 7'h20

`define PHPC_LAST_BIT 4'hf

`endif

// ### shared/phpc_pkg.sv
// Types shared by the peak and hold predriver controller
package phpc_pkg;
  typedef logic [6:0] phpc_dac_t;
  typedef logic [3:0] phpc_flt_t;

  typedef struct packed {
    logic wr;
    logic [2:0] addr;
    logic [3:0] rsvd;
    logic [7:0] data;
  } phpc_frame_t;

  typedef struct packed {
    logic [3:0] faults;
    logic rsvd;
    logic [2:0] addr;
    logic [7:0] data;
  } phpc_reply_t;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_PEAK,
    PH_HOLD
  } phpc_phase_t;
endpackage

// ### testbench/phpc_props.sv
// Port checks for the predriver controller
`timescale 1ns/1ps
module phpc_props (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic sclk_i,
  input wire logic chip_select_n_i,
  input wire logic sdo_oe_o,
  input wire logic output_permit_in_i,
  input wire logic cycle_ctrl_i,
  input wire phpc_pkg::phpc_dac_t load_current_i,
  input wire phpc_pkg::phpc_flt_t fault_detect_i,
  input wire logic gate_drive_o,
  input wire logic clamp_drive_o,
  input wire logic loop_state_o,
  input wire logic fault_n_o,
  input wire logic fault_oe_o
);
  import phpc_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  wire cmd_on = output_permit_in_i && cycle_ctrl_i;
  wire flt_on = |fault_detect_i;
  a_oe_cs: assert property (sdo_oe_o == !chip_select_n_i)
    else $error("sdo enable off select");
  a_oe_sclk: assert property (@(posedge sclk_i) disable iff (!resetn_i)
    !chip_select_n_i |-> sdo_oe_o)
    else $error("sdo idle in frame");
  // Two sync stages plus output register give three cycles of lag
  a_gate_cmd: assert property ((!cmd_on)[*4] |-> !gate_drive_o
    && !clamp_drive_o)
    else $error("drive without command");
  a_drive_excl: assert property (!(gate_drive_o && clamp_drive_o))
    else $error("gate and clamp both on");
  a_loop_full: assert property (load_current_i == 7'h7f |=>
    loop_state_o)
    else $error("loop low at full current");
  a_fault_pull: assert property (flt_on[*4] |-> fault_oe_o)
    else $error("fault pin not pulled");
  a_fault_low: assert property (fault_n_o == 1'b0)
    else $error("fault data not low");
  a_fault_block: assert property (flt_on[*5] |-> !gate_drive_o
    && !clamp_drive_o)
    else $error("drive during fault");
  a_reset_quiet: assert property ($rose(resetn_i) |-> !gate_drive_o
    && !clamp_drive_o && !fault_oe_o)
    else $error("outputs active after reset");
  c_gate: cover property ($rose(gate_drive_o));
  c_fault: cover property ($rose(fault_oe_o));
  c_frame: cover property ($fell(chip_select_n_i));
endmodule // phpc_props

// ### testbench/phpc_host.sv
// Host model: serial master sending 16-bit words
`timescale 1ns/1ps
module phpc_host (
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // Clock stands low between frames; the gap lets the reply settle
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    #37 cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      sdi_o = tx[i];
      #62.5 sclk_o = 1'b1;
      rx[i] = sdo_i;
      #62.5 sclk_o = 1'b0;
    end
    #30 cs_n_o = 1'b1;
    sdi_o = 1'b0;
    #500;
  endtask
endmodule // phpc_host

// ### testbench/phpc_top_tb.sv
// Self-checking bench for the predriver controller
`timescale 1ns/1ps
module phpc_top_tb;
  import phpc_pkg::*;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic output_permit_in_i = 1'b0;
  logic cycle_ctrl_i = 1'b0;
  logic dwell_source_sel_i = 1'b1;
  phpc_dac_t load_current_i = '0;
  phpc_flt_t fault_detect_i = '0;
  logic sclk_i, chip_select_n_i, sdi_i, sdo_o, sdo_oe_o, gate_drive_o;
  logic clamp_drive_o, loop_state_o, fault_n_o, fault_oe_o;
  wire sdo_pin = sdo_oe_o ? sdo_o : 1'bz;
  // External pull-up on the open-drain fault line
  wire fault_pin = fault_oe_o ? fault_n_o : 1'b1;
  int n_fail = 0;
  int comparisons = 0;
  logic [15:0] rx;
  phpc_dac_t pk;
  phpc_flt_t f;
  phpc_top phpc_top_i (.core_clk_i, .resetn_i, .sclk_i, .chip_select_n_i,
    .sdi_i, .sdo_o, .sdo_oe_o, .output_permit_in_i, .cycle_ctrl_i,
    .dwell_source_sel_i, .load_current_i, .fault_detect_i, .gate_drive_o,
    .clamp_drive_o, .loop_state_o, .fault_n_o, .fault_oe_o);
  phpc_host phpc_host_i (.sclk_o(sclk_i), .cs_n_o(chip_select_n_i),
    .sdi_o(sdi_i), .sdo_i(sdo_pin));
  initial
  begin
    forever #25 core_clk_i = ~core_clk_i;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task automatic chk(input string what, input logic [15:0] exp, got);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmd(input logic w, input logic [2:0] a, input logic [7:0] d);
    phpc_host_i.xfer({w, a, 4'h0, d}, rx);
  endtask
  function automatic logic [15:0] rep(input logic [2:0] a, logic [7:0] d);
    return {5'h00, a, d};
  endfunction
  // At, just below, full scale, then random currents
  task automatic loop_chk(input phpc_dac_t r);
    for (int i = 0; i < 12; i++)
    begin
      load_current_i = i == 0 ? r : i == 1 ? r - 7'h01
        : i == 2 ? 7'h7f : 7'($urandom);
      wt(2);
      chk("loop", 16'(load_current_i >= r), 16'(loop_state_o));
      chk("drive", {14'h0, load_current_i < r, load_current_i >= r},
        {14'h0, gate_drive_o, clamp_drive_o});
    end
  endtask
  task give_verdict;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'hbf37_b1de));
    wt(8);
    resetn_i = 1'b1;
    cmd(0, 3'h1, 8'h00);
    cmd(0, 3'h2, 8'h00);
    chk("aux rst", rep(3'h1, 8'h00), rx);
    cmd(0, 3'h3, 8'h00);
    chk("peak rst", rep(3'h2, 8'h40), rx);
    cmd(0, 3'h5, 8'h00);
    chk("hold rst", rep(3'h3, 8'h20), rx);
    pk = 7'($urandom_range(127, 1));
    cmd(1, 3'h2, {1'b0, pk});
    chk("unmapped", rep(3'h5, 8'h00), rx);
    cmd(1, 3'h1, 8'h08);
    chk("peak old", rep(3'h2, 8'h40), rx);
    cmd(0, 3'h2, 8'h00);
    chk("aux old", rep(3'h1, 8'h00), rx);
    cmd(0, 3'h1, 8'h00);
    chk("peak new", rep(3'h2, {1'b0, pk}), rx);
    wt(1);
    output_permit_in_i = 1'b1;
    cycle_ctrl_i = 1'b1;
    wt(6);
    loop_chk(pk);
    cycle_ctrl_i = 1'b0;
    dwell_source_sel_i = 1'b0;
    wt(6);
    cycle_ctrl_i = 1'b1;
    wt(6);
    loop_chk(7'h20);
    output_permit_in_i = 1'b0;
    wt(5);
    chk("no permit", 16'h0000, {14'h0, gate_drive_o, clamp_drive_o});
    output_permit_in_i = 1'b1;
    f = 4'($urandom_range(15, 1));
    fault_detect_i = f;
    wt(5);
    chk("fault", 16'h0002, {14'h0, fault_oe_o, fault_pin});
    chk("fault gate", 16'h0000, {15'h0, gate_drive_o});
    cmd(0, 3'h0, 8'h00);
    chk("aux new", rep(3'h1, 8'h08), rx);
    cmd(0, 3'h0, 8'h00);
    chk("status", {12'h000, f}, {12'h000, rx[15:12]});
    wt(1);
    fault_detect_i = '0;
    wt(5);
    cmd(0, 3'h0, 8'h00);
    wt(10);
    chk("fault clr", 16'h0001, {14'h0, fault_oe_o, fault_pin});
    cmd(1, 3'h2, 8'h60);
    cmd(1, 3'h1, 8'h01);
    chk("peak prev", rep(3'h2, {1'b0, pk}), rx);
    // Clock mode, dwell length 1: peak ends at the second dwell edge
    cycle_ctrl_i = 1'b0;
    load_current_i = 7'h40;
    wt(5);
    cycle_ctrl_i = 1'b1;
    wt(5);
    chk("peak ref", 16'h0000, 16'(loop_state_o));
    for (int i = 0; i < 2; i++)
    begin
      dwell_source_sel_i = 1'b1;
      wt(2);
      dwell_source_sel_i = 1'b0;
      wt(4);
      chk("dwell clk", 16'(i), 16'(loop_state_o));
    end
    // Reset in mid-run drops the drive and restores the defaults
    resetn_i = 1'b0;
    wt(2);
    chk("rst drive", 16'h0000, {14'h0, gate_drive_o, clamp_drive_o});
    resetn_i = 1'b1;
    cmd(0, 3'h2, 8'h00);
    cmd(0, 3'h1, 8'h00);
    chk("peak rst2", rep(3'h2, 8'h40), rx);
    give_verdict();
  end
  initial
  begin
    #500_000;
    n_fail++;
    give_verdict();
  end
endmodule // phpc_top_tb

bind phpc_top phpc_props phpc_props_i (.core_clk_i, .resetn_i, .sclk_i,
  .chip_select_n_i, .sdo_oe_o, .output_permit_in_i, .cycle_ctrl_i,
  .load_current_i, .fault_detect_i, .gate_drive_o, .clamp_drive_o,
  .loop_state_o, .fault_n_o, .fault_oe_o);
